// ---- rtl/pio_pkg.sv ----
// Purpose: shared constants and types for the parallel port block
// Assumes: one CPU-side clock, decoded 3-bit port address, rw high for reads
// Notes: data latches carry no reset value by design
//
// Overview of operation
// - Each of the three bidirectional ports has eight lines, each with its own direction bit and latch bit.
// - A direction bit at one makes its pin an output.
// - A direction bit at zero makes its pin an undriven input.
// - Reset clears every direction bit so all bidirectional pins become inputs.
// - An output pin drives the matching bit of its port data latch.
// - A data write to an input pin updates its latch while the pin stays undriven.
// - A data write to an output pin updates its latch and the new value appears on the pin at once.
// - A port read returns the sampled pin level for every bit whose direction bit is zero.
// - A port read returns the latch contents for every bit whose direction bit is one.
// - A four-line input-only port sits on the upper bits with no direction register and is never driven.
// - Reading the input-only port gives zeros on the low four bits and pin levels on the high four.
// - Reset leaves the data latches untouched and clears the direction bits, the pin synchronisers and the read data register.
package pio_pkg;

  localparam int NUM_BIDIR = 3;
  localparam int PORT_W = 8;
  localparam int IN_W = 4;
  localparam int ADDR_W = 3;

  // Decoded register addresses
  localparam logic [ADDR_W-1:0] ADDR_DATA_A = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_DATA_B = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_DATA_C = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_DATA_D = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_DIR_A = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_DIR_B = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_DIR_D = 3'h7;

  localparam logic [PORT_W-1:0] DIR_RESET = 8'h00;
  localparam logic [PORT_W-1:0] SYNC_RESET = 8'h00;
  localparam logic [PORT_W-1:0] RDATA_RESET = 8'h00;
  localparam logic [PORT_W-1:0] UNMAPPED_READ = 8'h00;
  localparam logic [IN_W-1:0] IN_SYNC_RESET = 4'h0;
  localparam logic [IN_W-1:0] IN_LOW_FILL = 4'h0;

  typedef struct packed {
    logic sel;
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic [PORT_W-1:0] wdata;
  } cpu_req_t;

  function automatic logic [ADDR_W-1:0] data_addr(input int idx);
    case (idx)
      0: data_addr = ADDR_DATA_A;
      1: data_addr = ADDR_DATA_B;
      default: data_addr = ADDR_DATA_D;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] dir_addr(input int idx);
    case (idx)
      0: dir_addr = ADDR_DIR_A;
      1: dir_addr = ADDR_DIR_B;
      default: dir_addr = ADDR_DIR_D;
    endcase
  endfunction

  function automatic logic is_write(input cpu_req_t req, input logic [ADDR_W-1:0] addr);
    is_write = req.sel && !req.rw && (req.addr == addr);
  endfunction

  function automatic logic is_read(input cpu_req_t req, input logic [ADDR_W-1:0] addr);
    is_read = req.sel && req.rw && (req.addr == addr);
  endfunction

endpackage

// ---- rtl/pio_port.sv ----
// Purpose: one eight-line bidirectional port with latch, direction and pin sampling
// Assumes: pin_in arrives asynchronously
// Notes: read_value is combinational; the parent registers it
`timescale 1ns/1ps
module pio_port import pio_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register access
  input wire logic wr_data,
  input wire logic wr_dir,
  input wire logic [PORT_W-1:0] wdata,
  // Pin side
  input wire logic [PORT_W-1:0] pin_in,
  output logic [PORT_W-1:0] latch,
  output logic [PORT_W-1:0] dir,
  output logic [PORT_W-1:0] read_value
);

  logic [PORT_W-1:0] next_latch;
  logic [PORT_W-1:0] next_dir;
  logic [PORT_W-1:0] sync1;
  logic [PORT_W-1:0] sync2;

  always_comb begin
    next_latch = wr_data ? wdata : latch;
    next_dir = wr_dir ? wdata : dir;
    read_value = (dir & latch) | (~dir & sync2);
  end

  // No reset: latch content survives a reset
  always_ff @(posedge core_clk) begin
    latch <= next_latch;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir <= DIR_RESET;
      sync1 <= SYNC_RESET;
      sync2 <= SYNC_RESET;
    end else begin
      dir <= next_dir;
      sync1 <= pin_in;
      sync2 <= sync1;
    end
  end

endmodule // pio_port

// ---- rtl/parallel_io_ports.sv ----
// Purpose: three bidirectional ports and one input-only port behind CPU accesses
// Assumes: pins are asynchronous; the CPU request is synchronous to core_clk
// Notes: read data appears one cycle after the read request and then holds
`timescale 1ns/1ps
module parallel_io_ports import pio_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // CPU access
  input wire cpu_req_t cpu_req,
  output logic [PORT_W-1:0] cpu_rdata,
  // First bidirectional port
  input wire logic [PORT_W-1:0] first_bidir_port_pins_in,
  output logic [PORT_W-1:0] first_bidir_port_pins_out,
  output logic [PORT_W-1:0] first_bidir_port_pins_oe,
  // Second bidirectional port
  input wire logic [PORT_W-1:0] second_bidir_port_pins_in,
  output logic [PORT_W-1:0] second_bidir_port_pins_out,
  output logic [PORT_W-1:0] second_bidir_port_pins_oe,
  // Third bidirectional port
  input wire logic [PORT_W-1:0] third_bidir_port_pins_in,
  output logic [PORT_W-1:0] third_bidir_port_pins_out,
  output logic [PORT_W-1:0] third_bidir_port_pins_oe,
  // Input-only port, upper nibble
  input wire logic [IN_W-1:0] input_only_port_pins
);

  logic [PORT_W-1:0] pin_in_arr [NUM_BIDIR];
  logic [PORT_W-1:0] latch_arr [NUM_BIDIR];
  logic [PORT_W-1:0] dir_arr [NUM_BIDIR];
  logic [PORT_W-1:0] rv_arr [NUM_BIDIR];
  logic [IN_W-1:0] in_sync1;
  logic [IN_W-1:0] in_sync2;
  logic [PORT_W-1:0] next_rdata;
  logic [IN_W-1:0] next_in_sync1;
  logic [IN_W-1:0] next_in_sync2;

  assign pin_in_arr[0] = first_bidir_port_pins_in;
  assign pin_in_arr[1] = second_bidir_port_pins_in;
  assign pin_in_arr[2] = third_bidir_port_pins_in;

  // Pin drivers are the port flops themselves, so pins never glitch on decode
  assign first_bidir_port_pins_out = latch_arr[0];
  assign second_bidir_port_pins_out = latch_arr[1];
  assign third_bidir_port_pins_out = latch_arr[2];
  assign first_bidir_port_pins_oe = dir_arr[0];
  assign second_bidir_port_pins_oe = dir_arr[1];
  assign third_bidir_port_pins_oe = dir_arr[2];

  for (genvar i = 0; i < NUM_BIDIR; i++) begin : g_port
    pio_port u_port (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .wr_data(is_write(cpu_req, data_addr(i))),
      .wr_dir(is_write(cpu_req, dir_addr(i))),
      .wdata(cpu_req.wdata),
      .pin_in(pin_in_arr[i]),
      .latch(latch_arr[i]),
      .dir(dir_arr[i]),
      .read_value(rv_arr[i])
    );
  end

  // Read mux; rdata holds between reads
  always_comb begin
    next_in_sync1 = input_only_port_pins;
    next_in_sync2 = in_sync1;
    next_rdata = cpu_rdata;
    if (cpu_req.sel && cpu_req.rw) begin
      case (cpu_req.addr)
        ADDR_DATA_A: next_rdata = rv_arr[0];
        ADDR_DATA_B: next_rdata = rv_arr[1];
        ADDR_DATA_D: next_rdata = rv_arr[2];
        ADDR_DATA_C: next_rdata = {in_sync2, IN_LOW_FILL};
        ADDR_DIR_A: next_rdata = dir_arr[0];
        ADDR_DIR_B: next_rdata = dir_arr[1];
        ADDR_DIR_D: next_rdata = dir_arr[2];
        default: next_rdata = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_sync1 <= IN_SYNC_RESET;
      in_sync2 <= IN_SYNC_RESET;
      cpu_rdata <= RDATA_RESET;
    end else begin
      in_sync1 <= next_in_sync1;
      in_sync2 <= next_in_sync2;
      cpu_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Checked even while reset is low, hence no disable
  dir_reset_a: assert property (disable iff (1'b0) !rst_n |->
    (first_bidir_port_pins_oe == DIR_RESET) && (second_bidir_port_pins_oe == DIR_RESET)
    && (third_bidir_port_pins_oe == DIR_RESET))
    else $error("direction bits not cleared by reset");

  dir_write_a: assert property (is_write(cpu_req, ADDR_DIR_B) |=>
    second_bidir_port_pins_oe == $past(cpu_req.wdata))
    else $error("direction write did not reach pin enables");

  input_write_a: assert property ((is_write(cpu_req, ADDR_DATA_A) && first_bidir_port_pins_oe == DIR_RESET
    && !is_write(cpu_req, ADDR_DIR_A)) |=> first_bidir_port_pins_oe == DIR_RESET
    && first_bidir_port_pins_out == $past(cpu_req.wdata))
    else $error("data write to input port changed drive");

  output_write_a: assert property (is_write(cpu_req, ADDR_DATA_D) |=>
    third_bidir_port_pins_out == $past(cpu_req.wdata) && $stable(third_bidir_port_pins_oe))
    else $error("data write did not appear on the pins");

  latch_hold_a: assert property (disable iff (1'b0)
    (rst_n !== 1'b1 || !is_write(cpu_req, ADDR_DATA_B)) |=> $stable(second_bidir_port_pins_out))
    else $error("data latch changed without a write");

  input_read_a: assert property ((is_read(cpu_req, ADDR_DATA_A) && first_bidir_port_pins_oe == DIR_RESET
    && $past(rst_n, 3)) |=> cpu_rdata == $past(first_bidir_port_pins_in, 3))
    else $error("input read did not return pin level");

  output_read_a: assert property ((is_read(cpu_req, ADDR_DATA_D) && third_bidir_port_pins_oe == 8'hFF)
    |=> cpu_rdata == $past(third_bidir_port_pins_out))
    else $error("output read did not return latch");

  fixed_read_a: assert property ((is_read(cpu_req, ADDR_DATA_C) && $past(rst_n, 3)) |=>
    cpu_rdata == {$past(input_only_port_pins, 3), IN_LOW_FILL})
    else $error("input-only read wrong");

  unmapped_read_a: assert property ((cpu_req.sel && cpu_req.rw && cpu_req.addr == 3'h6)
    |=> cpu_rdata == UNMAPPED_READ)
    else $error("unmapped read not zero");

  read_hold_a: assert property (!(cpu_req.sel && cpu_req.rw) |=> $stable(cpu_rdata))
    else $error("read data changed without a read");

  // Per-port copies, so a fault confined to one port still shows
  localparam logic [ADDR_W-1:0] ADDR_UNMAPPED = 3'h6;

  dir_write_first_a: assert property (is_write(cpu_req, ADDR_DIR_A) |=>
    first_bidir_port_pins_oe == $past(cpu_req.wdata))
    else $error("first port direction write lost");

  dir_write_third_a: assert property (is_write(cpu_req, ADDR_DIR_D) |=>
    third_bidir_port_pins_oe == $past(cpu_req.wdata))
    else $error("third port direction write lost");

  data_write_first_a: assert property (is_write(cpu_req, ADDR_DATA_A) |=>
    first_bidir_port_pins_out == $past(cpu_req.wdata) && $stable(first_bidir_port_pins_oe))
    else $error("first port data write did not reach the pins");

  data_write_second_a: assert property (is_write(cpu_req, ADDR_DATA_B) |=>
    second_bidir_port_pins_out == $past(cpu_req.wdata) && $stable(second_bidir_port_pins_oe))
    else $error("second port data write did not reach the pins");

  input_write_second_a: assert property (is_write(cpu_req, ADDR_DATA_B)
    && second_bidir_port_pins_oe == DIR_RESET |=> second_bidir_port_pins_oe == DIR_RESET
    && second_bidir_port_pins_out == $past(cpu_req.wdata))
    else $error("second port input write changed drive");

  input_write_third_a: assert property (is_write(cpu_req, ADDR_DATA_D)
    && third_bidir_port_pins_oe == DIR_RESET |=> third_bidir_port_pins_oe == DIR_RESET
    && third_bidir_port_pins_out == $past(cpu_req.wdata))
    else $error("third port input write changed drive");

  dir_hold_first_a: assert property (!is_write(cpu_req, ADDR_DIR_A) |=> $stable(first_bidir_port_pins_oe))
    else $error("first port direction changed without a write");

  dir_hold_second_a: assert property (!is_write(cpu_req, ADDR_DIR_B) |=> $stable(second_bidir_port_pins_oe))
    else $error("second port direction changed without a write");

  dir_hold_third_a: assert property (!is_write(cpu_req, ADDR_DIR_D) |=> $stable(third_bidir_port_pins_oe))
    else $error("third port direction changed without a write");

  mixed_read_first_a: assert property (is_read(cpu_req, ADDR_DATA_A) && $past(rst_n, 3) |=>
    cpu_rdata == (($past(first_bidir_port_pins_oe) & $past(first_bidir_port_pins_out))
    | (~$past(first_bidir_port_pins_oe) & $past(first_bidir_port_pins_in, 3))))
    else $error("first port read mixed latch and pins wrongly");

  mixed_read_second_a: assert property (is_read(cpu_req, ADDR_DATA_B) && $past(rst_n, 3) |=>
    cpu_rdata == (($past(second_bidir_port_pins_oe) & $past(second_bidir_port_pins_out))
    | (~$past(second_bidir_port_pins_oe) & $past(second_bidir_port_pins_in, 3))))
    else $error("second port read mixed latch and pins wrongly");

  mixed_read_third_a: assert property (is_read(cpu_req, ADDR_DATA_D) && $past(rst_n, 3) |=>
    cpu_rdata == (($past(third_bidir_port_pins_oe) & $past(third_bidir_port_pins_out))
    | (~$past(third_bidir_port_pins_oe) & $past(third_bidir_port_pins_in, 3))))
    else $error("third port read mixed latch and pins wrongly");

  dir_read_first_a: assert property (is_read(cpu_req, ADDR_DIR_A) |=>
    cpu_rdata == $past(first_bidir_port_pins_oe))
    else $error("first port direction read wrong");

  dir_read_second_a: assert property (is_read(cpu_req, ADDR_DIR_B) |=>
    cpu_rdata == $past(second_bidir_port_pins_oe))
    else $error("second port direction read wrong");

  dir_read_third_a: assert property (is_read(cpu_req, ADDR_DIR_D) |=>
    cpu_rdata == $past(third_bidir_port_pins_oe))
    else $error("third port direction read wrong");

  fixed_write_a: assert property (is_write(cpu_req, ADDR_DATA_C) |=>
    $stable({first_bidir_port_pins_oe, second_bidir_port_pins_oe, third_bidir_port_pins_oe})
    && $stable({first_bidir_port_pins_out, second_bidir_port_pins_out, third_bidir_port_pins_out}))
    else $error("write to the input-only port changed a pin");

  unmapped_write_a: assert property ((cpu_req.sel && !cpu_req.rw && cpu_req.addr == ADDR_UNMAPPED) |=>
    $stable({first_bidir_port_pins_oe, second_bidir_port_pins_oe, third_bidir_port_pins_oe})
    && $stable({first_bidir_port_pins_out, second_bidir_port_pins_out, third_bidir_port_pins_out}))
    else $error("unmapped write changed a pin");

  rdata_reset_a: assert property (disable iff (1'b0) !rst_n |-> cpu_rdata == RDATA_RESET)
    else $error("read data not cleared by reset");

  dir_then_read_c: cover property (is_write(cpu_req, ADDR_DIR_A) ##[1:8] is_read(cpu_req, ADDR_DATA_A));
  fixed_read_c: cover property (is_read(cpu_req, ADDR_DATA_C));
  input_write_c: cover property (is_write(cpu_req, ADDR_DATA_B) && second_bidir_port_pins_oe == DIR_RESET);
  mixed_dir_c: cover property (is_read(cpu_req, ADDR_DATA_D)
    && !(third_bidir_port_pins_oe inside {DIR_RESET, 8'hFF}));

endmodule // parallel_io_ports

// ---- tb/pin_ext_model.sv ----
// Purpose: external circuitry on one eight-line port, resolving each wire
// Assumes: the outside source yields a line whenever the port drives it
// Notes: undriven lines show the outside source, never a held old value
`timescale 1ns/1ps
module pin_ext_model (
  // Port side
  input wire logic [7:0] drv_out,
  input wire logic [7:0] drv_oe,
  // Outside source and resolved wire
  input wire logic [7:0] ext,
  output logic [7:0] level
);
  // Per-bit wire: port value where enabled, outside source elsewhere
  assign level = (drv_oe & drv_out) | (~drv_oe & ext);
endmodule // pin_ext_model

// ---- tb/parallel_io_ports_test.sv ----
// Purpose: self-checking bench for the parallel port block
// Assumes: reads answer just after the edge that takes them
// Notes: pins are held three cycles before a read so the synchronisers settle
`timescale 1ns/1ps
module parallel_io_ports_test import pio_pkg::*;;
  logic core_clk;
  logic rst_n;
  cpu_req_t cpu_req;
  logic [PORT_W-1:0] cpu_rdata;
  logic [IN_W-1:0] in4;
  logic [2:0][7:0] pout, poe, lvl, ext;
  int num_errors = 0;
  int samples_checked = 0;
  int lat_m[3];
  int dir_m[3];
  int exp_q[$];
  logic [31:0] seed = 32'h0000D3DA;
  localparam logic [2:0] DADR [3] = '{ADDR_DATA_A, ADDR_DATA_B, ADDR_DATA_D};
  localparam logic [2:0] RADR [3] = '{ADDR_DIR_A, ADDR_DIR_B, ADDR_DIR_D};

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  parallel_io_ports dut_u (.core_clk(core_clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .first_bidir_port_pins_in(lvl[0]), .first_bidir_port_pins_out(pout[0]), .first_bidir_port_pins_oe(poe[0]),
    .second_bidir_port_pins_in(lvl[1]), .second_bidir_port_pins_out(pout[1]), .second_bidir_port_pins_oe(poe[1]),
    .third_bidir_port_pins_in(lvl[2]), .third_bidir_port_pins_out(pout[2]), .third_bidir_port_pins_oe(poe[2]),
    .input_only_port_pins(in4));

  for (genvar i = 0; i < 3; i++) begin : g_pin
    pin_ext_model pm_u (.drv_out(pout[i]), .drv_oe(poe[i]), .ext(ext[i]), .level(lvl[i]));
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One access; returns once its result has settled
  task automatic acc(input logic r, input logic [2:0] a, input logic [7:0] wd);
    @(posedge core_clk);
    cpu_req <= '{1'b1, r, a, wd};
    @(posedge core_clk);
    cpu_req.sel <= 1'b0;
    #1;
  endtask

  task automatic results();
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    results();
  end

  initial begin
    int p;
    int x;
    logic [31:0] e;
    logic [7:0] d, v;
    // Start high so the drop is a real falling edge for the async reset
    rst_n = 1'b1;
    cpu_req = '0;
    in4 = 4'h0;
    ext = '0;
    #1;
    rst_n = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    for (p = 0; p < 3; p++) chk(poe[p], 8'h00);
    chk(cpu_rdata, 8'h00);
    // Latches power up unknown, so give them a known start
    for (p = 0; p < 3; p++) begin
      acc(1'b0, DADR[p], 8'h00);
      lat_m[p] = 0;
      dir_m[p] = 0;
    end
    for (int i = 0; i < 24; i++) begin
      p = int'(rnd() % 3);
      d = 8'(rnd());
      v = 8'(rnd());
      acc(1'b0, DADR[p], v);
      chk(pout[p], v);
      acc(1'b0, RADR[p], d);
      chk(poe[p], d);
      lat_m[p] = int'(v);
      dir_m[p] = int'(d);
      e = rnd();
      @(posedge core_clk);
      ext[p] <= e[7:0];
      in4 <= e[11:8];
      repeat (3) @(posedge core_clk);
      chk(pout[p], v);
      x = (dir_m[p] & lat_m[p]) | (~dir_m[p] & int'(e[7:0]));
      exp_q.push_back(x);
      acc(1'b1, DADR[p], 8'h00);
      chk(cpu_rdata, 8'(exp_q.pop_front()));
      acc(1'b1, RADR[p], 8'h00);
      chk(cpu_rdata, d);
      acc(1'b1, ADDR_DATA_C, 8'h00);
      chk(cpu_rdata, {e[11:8], 4'h0});
      acc(1'b0, ADDR_DATA_C, ~v);
      acc(1'b0, 3'h6, ~v);
      chk(pout[p], v);
      chk(poe[p], d);
      acc(1'b1, 3'h6, 8'h00);
      chk(cpu_rdata, 8'h00);
    end
    // Reset in mid-run: directions clear, latches keep their data
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    #1;
    for (p = 0; p < 3; p++) begin
      chk(poe[p], 8'h00);
      chk(pout[p], 8'(lat_m[p]));
    end
    @(posedge core_clk);
    rst_n <= 1'b1;
    // After release: directions still clear, latch survives, input pins read back
    acc(1'b1, RADR[2], 8'h00);
    chk(cpu_rdata, 8'h00);
    acc(1'b0, RADR[2], 8'hFF);
    acc(1'b1, DADR[2], 8'h00);
    chk(cpu_rdata, 8'(lat_m[2]));
    acc(1'b1, DADR[0], 8'h00);
    chk(cpu_rdata, ext[0]);
    results();
  end
endmodule // parallel_io_ports_test
